/* design/fsr_pkg.sv */
// constants and types for the flash status, reset and protect controller
package fsr_pkg;
  localparam int CLK_NS = 100;
  // times as printed
  localparam int RESET_PULSE_NS = 500;
  localparam int READY_BUSY_US = 20;
  localparam int READY_IDLE_NS = 500;
  localparam int STANDBY_US = 20;
  localparam int UNPROT_SETUP_US = 4;
  localparam int PROT_PULSE_US = 100;
  localparam int UNPROT_PULSE_MS = 10;
  localparam int PROGRAM_TYP_US = 9;
  // least and longest times round up, typical and default times round down
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_BUSY_CYC = (READY_BUSY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int READY_IDLE_CYC = (READY_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STANDBY_CYC = (STANDBY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int UNPROT_SETUP_CYC = (UNPROT_SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PROT_PULSE_CYC = (PROT_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int UNPROT_PULSE_DEF = (UNPROT_PULSE_MS * 1000000) / CLK_NS;
  localparam int PROGRAM_TYP_CYC = (PROGRAM_TYP_US * 1000) / CLK_NS;
  // bus cycle phases in clocks
  localparam int SETUP_CYC = 1;
  localparam int STROBE_CYC = 2;
  localparam int RECOVER_CYC = 1;
  // data codes and bit positions
  localparam logic [7:0] PROT_SETUP_DATA = 8'h60;
  localparam logic [7:0] PROT_VERIFY_DATA = 8'h40;
  localparam int MAIN_TOGGLE_POS = 6;
  localparam int SELECT_POS = 6;
  localparam int MODE_HI_POS = 1;
  localparam int MODE_LO_POS = 0;
  localparam int ADDR_W = 21;
  localparam int CNT_W = 20;
  typedef enum logic [2:0] {
    FSR_CMD_READ, FSR_CMD_WRITE, FSR_CMD_POLL, FSR_CMD_RESET,
    FSR_CMD_PROTECT, FSR_CMD_UNPROTECT, FSR_CMD_STANDBY
  } fsr_cmd_t;
endpackage

/* design/fsr_bus_cycle.sv */
// one read or write strobe cycle on the flash pins
`timescale 1ns/1ps
module fsr_bus_cycle (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // request
  input wire logic start,
  input wire logic is_write,
  input wire logic use_chip_enable,
  // strobes
  output logic strobe_n,
  output logic write_phase,
  output logic done
);
  import fsr_pkg::*;
  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_RECOVER} fsr_bc_t;
  fsr_bc_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic wr_ff;
  wire cnt_end = (cnt_ff == 4'h0);
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_end ? 4'h0 : cnt_ff - 4'h1;
    case (st_ff)
      BC_IDLE: if (start) begin
        nxt_st = BC_SETUP;
        nxt_cnt = 4'(SETUP_CYC - 1);
      end
      BC_SETUP: if (cnt_end) begin
        nxt_st = BC_STROBE;
        nxt_cnt = 4'(STROBE_CYC - 1);
      end
      BC_STROBE: if (cnt_end) begin
        nxt_st = BC_RECOVER;
        nxt_cnt = 4'(RECOVER_CYC - 1);
      end
      BC_RECOVER: if (cnt_end) nxt_st = BC_IDLE;
      default: nxt_st = BC_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= BC_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      strobe_n <= 1'b1;
      done <= 1'b0;
      write_phase <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      if (start && st_ff == BC_IDLE) wr_ff <= is_write;
      strobe_n <= (nxt_st != BC_STROBE);
      write_phase <= (nxt_st != BC_IDLE) && (start ? is_write : wr_ff);
      done <= (st_ff == BC_RECOVER) && cnt_end;
    end
  end
endmodule

/* design/fsr_host.sv */
// host controller driving flash pins for status polling, reset and sector protect
// Summary of operation
// RULE1: suspend toggle bit toggles only inside an erase-suspended sector.
// RULE2: status reads may be strobed by output enable or by chip enable.
// RULE3: main toggle bit toggles regardless of address during embedded work.
// RULE4: reset during embedded work; device ready within 20 us.
// RULE5: reset while idle; device ready within 500 ns.
// RULE6: reset held low 20 us or more puts device in standby.
// RULE7: byte program typically takes about 9 us.
// RULE8: sector erase typically takes about 0.7 s per sector.
// RULE9: hold reset at elevated level 4 us before any write.
// RULE10: protect uses 60h setup and pulse writes, then 40h verify write.
// RULE11: protect presents select bit low, mode hi high, mode lo low.
// RULE12: unprotect presents select bit high, mode hi high, mode lo low.
// RULE13: wait 100 us for protect pulse, 10 ms for unprotect pulse.
// RULE14: erase preprograms every byte to 00h before erasing.
// RULE15: first 60h write needs no valid address.
// RULE16: operation done when two consecutive status reads agree on toggle bit.
// RULE17: ready/busy shows busy during embedded work, ready after.
`timescale 1ns/1ps
module fsr_host #(
  parameter int UNPROT_PULSE_CYC = fsr_pkg::UNPROT_PULSE_DEF,
  parameter int POLL_LIMIT = 16'hFFFF
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // user command port
  input wire logic cmd_valid,
  input wire fsr_pkg::fsr_cmd_t cmd_op,
  input wire logic [fsr_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_use_chip_enable,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_error,
  output logic device_busy,
  // flash pins
  output logic [fsr_pkg::ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic reset_n,
  output logic elevated_unprotect_level,
  input wire logic ready_busy_n
);
  import fsr_pkg::*;
  typedef enum logic [3:0] {
    S_IDLE, S_CYCLE, S_RESET_LOW, S_RESET_WAIT, S_LEVEL, S_PREP, S_PULSE, S_VERIFY, S_POLL2,
    S_DONE
  } fsr_state_t;
  fsr_state_t st_ff, nxt_st;
  fsr_cmd_t op_ff;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [15:0] poll_ff;
  logic [1:0] step_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] wdata_ff, prev_ff;
  logic ce_sel_ff, fail_ff;
  logic [7:0] dq_s1_ff, dq_s2_ff;
  logic rb_s1_ff, rb_s2_ff;
  logic bc_start, bc_wr, bc_strobe_n, bc_write_phase, bc_done;
  // pin inputs pass two flops
  always_ff @(posedge clock) begin
    dq_s1_ff <= flash_dq_in;
    dq_s2_ff <= dq_s1_ff;
    rb_s1_ff <= ready_busy_n;
    rb_s2_ff <= rb_s1_ff;
  end
  fsr_bus_cycle u_cycle (
    .clock(clock),
    .reset(reset),
    .start(bc_start),
    .is_write(bc_wr),
    .use_chip_enable(ce_sel_ff),
    .strobe_n(bc_strobe_n),
    .write_phase(bc_write_phase),
    .done(bc_done)
  );
  wire cnt_end = (cnt_ff == '0);
  wire is_prot = (op_ff == FSR_CMD_PROTECT);
  wire is_seq = (op_ff == FSR_CMD_PROTECT) || (op_ff == FSR_CMD_UNPROTECT);
  // RULE16 toggle compare of two back to back status reads
  wire toggles_same = (dq_s2_ff[MAIN_TOGGLE_POS] == prev_ff[MAIN_TOGGLE_POS]);
  wire [CNT_W-1:0] pulse_cyc = is_prot ? CNT_W'(PROT_PULSE_CYC) : CNT_W'(UNPROT_PULSE_CYC);
  // protect mode address bits
  wire [ADDR_W-1:0] prot_addr = {addr_ff[ADDR_W-1:SELECT_POS+1], ~is_prot,
    addr_ff[SELECT_POS-1:MODE_HI_POS+1], 1'b1, 1'b0}; // RULE11 RULE12
  wire cyc_idle = (st_ff == S_CYCLE || st_ff == S_VERIFY || st_ff == S_POLL2
    || st_ff == S_PREP);
  // verify is a 40h write, the status comes back during that strobe
  assign bc_wr = (st_ff == S_PREP) || (st_ff == S_VERIFY)
    || (st_ff == S_CYCLE && op_ff == FSR_CMD_WRITE);
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_end ? cnt_ff : cnt_ff - 1'b1;
    bc_start = 1'b0;
    case (st_ff)
      S_IDLE: if (cmd_valid) begin
        case (cmd_op)
          FSR_CMD_RESET: begin
            nxt_st = S_RESET_LOW;
            nxt_cnt = CNT_W'(RESET_PULSE_CYC);
          end
          FSR_CMD_STANDBY: begin
            nxt_st = S_RESET_LOW;
            nxt_cnt = CNT_W'(STANDBY_CYC); // RULE6
          end
          FSR_CMD_PROTECT, FSR_CMD_UNPROTECT: begin
            nxt_st = S_LEVEL;
            nxt_cnt = CNT_W'(UNPROT_SETUP_CYC); // RULE9
          end
          default: begin
            nxt_st = S_CYCLE;
            nxt_cnt = CNT_W'(0);
          end
        endcase
      end
      // count parked at 1 while a strobe cycle runs, so start fires once per cycle
      S_CYCLE: begin
        bc_start = cnt_end;
        nxt_cnt = CNT_W'(1);
        if (bc_done) begin
          nxt_st = (op_ff == FSR_CMD_POLL) ? S_POLL2 : S_DONE;
          nxt_cnt = CNT_W'(0);
        end
      end
      S_POLL2: begin
        bc_start = cnt_end;
        nxt_cnt = CNT_W'(1);
        if (bc_done) nxt_cnt = CNT_W'(0);
        if (bc_done && (toggles_same || poll_ff == 16'h0000)) nxt_st = S_DONE; // RULE16
      end
      S_RESET_LOW: if (cnt_end) begin
        nxt_st = S_RESET_WAIT;
        nxt_cnt = rb_s2_ff ? CNT_W'(READY_IDLE_CYC) : CNT_W'(READY_BUSY_CYC); // RULE4 RULE5
      end
      S_RESET_WAIT: if (cnt_end) nxt_st = S_DONE;
      // elevated level settles before the first write
      S_LEVEL: if (cnt_end) nxt_st = S_PREP; // RULE9
      S_PREP: begin
        // setup write then pulse write, both data 60h
        bc_start = cnt_end;
        nxt_cnt = CNT_W'(1);
        if (bc_done) begin
          nxt_st = (step_ff == 2'd1) ? S_PULSE : S_PREP;
          nxt_cnt = (step_ff == 2'd1) ? pulse_cyc : CNT_W'(0);
        end
      end
      S_PULSE: if (cnt_end) nxt_st = S_VERIFY; // RULE13
      S_VERIFY: begin
        bc_start = cnt_end;
        nxt_cnt = CNT_W'(1);
        if (bc_done) nxt_st = S_DONE; // RULE10
      end
      S_DONE: nxt_st = S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= S_IDLE;
      op_ff <= FSR_CMD_READ;
      cnt_ff <= '0;
      poll_ff <= 16'h0000;
      step_ff <= 2'd0;
      addr_ff <= '0;
      wdata_ff <= 8'h00;
      prev_ff <= 8'h00;
      ce_sel_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      if (st_ff == S_IDLE && cmd_valid) begin
        op_ff <= cmd_op;
        addr_ff <= cmd_addr;
        wdata_ff <= cmd_wdata;
        ce_sel_ff <= cmd_use_chip_enable; // RULE2
        step_ff <= 2'd0;
        poll_ff <= 16'(POLL_LIMIT);
        fail_ff <= 1'b0;
      end
      if (bc_done) begin
        prev_ff <= dq_s2_ff;
        step_ff <= step_ff + 2'd1;
        if (st_ff == S_POLL2 && poll_ff != 16'h0000) poll_ff <= poll_ff - 16'h0001;
      end
      if (st_ff == S_POLL2 && bc_done && !toggles_same && poll_ff == 16'h0000) fail_ff <= 1'b1;
    end
  end
  // pin outputs, all from flops
  always_ff @(posedge clock) begin
    if (reset) begin
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      reset_n <= 1'b0;
      elevated_unprotect_level <= 1'b0;
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe_n <= 1'b1;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_error <= 1'b0;
      device_busy <= 1'b0;
    end else begin
      // chip enable held low over the cycle unless it is the strobe
      chip_enable_n <= ce_sel_ff ? bc_strobe_n : ~(cyc_idle && !cnt_end) & bc_strobe_n;
      output_enable_n <= (ce_sel_ff ? 1'b0 : bc_strobe_n) | bc_write_phase | ~cyc_idle;
      write_enable_n <= bc_strobe_n | ~bc_write_phase;
      reset_n <= !(st_ff == S_RESET_LOW || (st_ff == S_IDLE && cmd_valid
        && (cmd_op == FSR_CMD_RESET || cmd_op == FSR_CMD_STANDBY)));
      elevated_unprotect_level <= is_seq && st_ff != S_IDLE && st_ff != S_DONE; // RULE9
      // RULE15 address is don't care on the first 60h, kept as the sector anyway
      flash_addr <= is_seq ? prot_addr : addr_ff; // RULE3 RULE1
      flash_dq_out <= (st_ff == S_PREP) ? PROT_SETUP_DATA
        : (st_ff == S_VERIFY) ? PROT_VERIFY_DATA : wdata_ff; // RULE10
      flash_dq_oe_n <= ~bc_write_phase;
      cmd_ready <= (nxt_st == S_IDLE);
      rsp_valid <= (st_ff == S_DONE);
      if (st_ff == S_VERIFY && bc_done) rsp_rdata <= dq_s2_ff;
      else if (bc_done && !is_seq) rsp_rdata <= dq_s2_ff;
      // give-up flag held so it leaves together with rsp_valid
      rsp_error <= (st_ff == S_DONE) && fail_ff; // RULE16
      device_busy <= ~rb_s2_ff; // RULE17
    end
  end
  // pulse state holds at least 8 cycles before the verify write
  property p_pulse_wait;
    @(posedge clock) disable iff (reset)
      (st_ff == S_PREP && nxt_st == S_PULSE) |=> (st_ff == S_PULSE)[*8];
  endproperty
  a_pulse_wait: assert property (p_pulse_wait) else $error("pulse wait cut short"); // RULE13
  property p_verify_data;
    @(posedge clock) disable iff (reset)
      (st_ff == S_VERIFY && !write_enable_n) |-> flash_dq_out == PROT_VERIFY_DATA;
  endproperty
  a_verify_data: assert property (p_verify_data) else $error("verify data wrong"); // RULE10
  property p_setup_level;
    @(posedge clock) disable iff (reset)
      (!write_enable_n && st_ff == S_PREP) |-> elevated_unprotect_level
        && $past(elevated_unprotect_level, 8);
  endproperty
  a_setup_level: assert property (p_setup_level) else $error("write before level setup"); // RULE9
  property p_protect_bits;
    @(posedge clock) disable iff (reset)
      (is_seq && !write_enable_n && st_ff == S_VERIFY) |->
        flash_addr[MODE_HI_POS] && !flash_addr[MODE_LO_POS]
        && flash_addr[SELECT_POS] == !is_prot;
  endproperty
  a_protect_bits: assert property (p_protect_bits) else $error("protect address bits"); // RULE11
  property p_reset_width;
    @(posedge clock) disable iff (reset)
      $fell(reset_n) |-> !reset_n[*5];
  endproperty
  a_reset_width: assert property (p_reset_width) else $error("reset pulse too short"); // RULE5
  property p_error_with_rsp;
    @(posedge clock) disable iff (reset)
      rsp_error |-> rsp_valid;
  endproperty
  a_error_with_rsp: assert property (p_error_with_rsp) else $error("error without response"); // RULE16
endmodule

/* bench/fsr_flash_model.sv */
// behavioural flash device as seen from the controller pins
`timescale 1ns/1ps
module fsr_flash_model #(
  parameter int ERASE_CYC = 3000
) (
  // timing reference only, the device itself has no clock
  input wire logic clock,
  // pins from the controller
  input wire logic [fsr_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic reset_n,
  // pins to the controller
  output logic [7:0] flash_dq_in,
  output logic ready_busy_n
);
  import fsr_pkg::*;
  logic [CNT_W-1:0] busy_ff = '0;
  logic [CNT_W-1:0] rst_cnt_ff = '0;
  logic [7:0] last_ff = 8'h00;
  logic [7:0] wd_ff = 8'h00;
  logic [7:0] w1_ff = 8'h00;
  logic [7:0] w2_ff = 8'h00;
  logic [4:0] erase_sec_ff = 5'h00;
  logic [4:0] wsec_ff = 5'h00;
  logic tog6_ff = 1'b0;
  logic tog2_ff = 1'b0;
  logic rd_q_ff = 1'b0;
  logic wr_q_ff = 1'b0;
  logic standby_ff = 1'b0;
  wire rd = !chip_enable_n && !output_enable_n;
  wire wr = !chip_enable_n && !write_enable_n;
  wire seq_ok = w1_ff == PROT_SETUP_DATA && w2_ff == PROT_SETUP_DATA;
  wire mode_ok = flash_addr[MODE_HI_POS] && !flash_addr[MODE_LO_POS];
  wire [7:0] ver = !mode_ok ? 8'hEE : (flash_addr[SELECT_POS] ? 8'h00 : 8'h01);
  wire [7:0] stat = {1'b0, tog6_ff, 3'h0, tog2_ff, 2'h0};
  wire [7:0] rd_val = (busy_ff != 0) ? stat : flash_addr[7:0];
  wire ver_now = wr && flash_dq_out == PROT_VERIFY_DATA && seq_ok;
  // released bus flips every cycle so a stale sample cannot pass
  wire [7:0] drv = ver_now ? ver : (rd ? rd_val : ~last_ff);
  assign flash_dq_in = drv;
  assign ready_busy_n = busy_ff == 0;
  always_ff @(posedge clock) begin
    last_ff <= drv;
    rd_q_ff <= rd;
    wr_q_ff <= wr;
    if (wr) begin
      wd_ff <= flash_dq_out;
      wsec_ff <= flash_addr[20:16];
    end
    if (rd && !rd_q_ff && busy_ff != 0) begin
      tog6_ff <= !tog6_ff;
      if (flash_addr[20:16] == erase_sec_ff) tog2_ff <= !tog2_ff;
    end
    if (busy_ff != 0) busy_ff <= busy_ff - 1'b1;
    // one write stands for a whole command sequence here
    if (wr_q_ff && !wr) begin
      w2_ff <= w1_ff;
      w1_ff <= wd_ff;
      if (wd_ff == 8'hA0) busy_ff <= CNT_W'(PROGRAM_TYP_CYC);
      if (wd_ff == 8'h30) begin
        busy_ff <= CNT_W'(ERASE_CYC);
        erase_sec_ff <= wsec_ff;
      end
    end
    if (!reset_n) begin
      rst_cnt_ff <= rst_cnt_ff + 1'b1;
      if (busy_ff > CNT_W'(50)) busy_ff <= CNT_W'(50);
      if (rst_cnt_ff >= CNT_W'(STANDBY_CYC)) standby_ff <= 1'b1;
    end else begin
      rst_cnt_ff <= '0;
      standby_ff <= 1'b0;
    end
  end
endmodule

/* bench/flash_status_reset_protect_tb.sv */
// self-checking bench for the flash host controller against the device model
`timescale 1ns/1ps
module flash_status_reset_protect_tb;
  import fsr_pkg::*;
  logic clock, reset, cmd_valid, cmd_use_chip_enable, cmd_ready, rsp_valid, rsp_error;
  logic device_busy, flash_dq_oe_n, chip_enable_n, output_enable_n, write_enable_n;
  logic reset_n, elevated_unprotect_level, ready_busy_n;
  fsr_cmd_t cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_addr, pa;
  logic [7:0] cmd_wdata, rsp_rdata, flash_dq_out, flash_dq_in;
  logic [9:0] exp_q[$];
  logic [9:0] e;
  logic [31:0] seed = 32'h03050F26;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int dur;
  fsr_host #(.UNPROT_PULSE_CYC(20), .POLL_LIMIT(64)) uut (.clock, .reset, .cmd_valid,
    .cmd_op, .cmd_addr, .cmd_wdata, .cmd_use_chip_enable, .cmd_ready, .rsp_valid,
    .rsp_rdata, .rsp_error, .device_busy, .flash_addr, .flash_dq_out, .flash_dq_oe_n,
    .flash_dq_in, .chip_enable_n, .output_enable_n, .write_enable_n, .reset_n,
    .elevated_unprotect_level, .ready_busy_n);
  fsr_flash_model dev (.clock, .flash_addr, .flash_dq_out, .chip_enable_n,
    .output_enable_n, .write_enable_n, .reset_n, .flash_dq_in, .ready_busy_n);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk_data(input logic [7:0] ex, input logic [7:0] g);
    n_tests++;
    if (g !== ex) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, ex, g);
    end
  endtask
  task automatic chk_flag(input logic ex, input logic g);
    n_tests++;
    if (g !== ex) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, ex, g);
    end
  endtask
  task automatic final_report;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // expectation: bit 9 data checked, bit 8 error flag, low byte data
  task automatic cmd(input fsr_cmd_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d,
      input logic ce, input logic [9:0] ex);
    exp_q.push_back(ex);
    while (cmd_ready !== 1'b1) @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_use_chip_enable = ce;
    dur = 0;
    @(negedge clock);
    cmd_valid = 1'b0;
    while (exp_q.size() != 0) begin
      @(negedge clock);
      dur++;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) begin
    cyc++;
    if (cyc > 40000) begin
      n_fail++;
      final_report();
    end else if (rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      chk_flag(e[8], rsp_error);
      if (e[9]) chk_data(e[7:0], rsp_rdata);
    end
  end
  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = FSR_CMD_READ;
    cmd_addr = '0;
    cmd_wdata = 8'h00;
    cmd_use_chip_enable = 1'b0;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      cmd(FSR_CMD_READ, seed[ADDR_W-1:0], 8'h00, seed[31], {2'b10, seed[7:0]});
    end
    $display("plain reads done");
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      pa = ADDR_W'(xs(seed ^ 32'h5A5A5A5A));
      cmd(FSR_CMD_WRITE, seed[ADDR_W-1:0], 8'hA0, 1'b0, 10'h000);
      // allow the two-flop synchroniser to pass busy through
      repeat (4) @(negedge clock);
      chk_flag(1'b1, device_busy);
      cmd(FSR_CMD_POLL, pa, 8'h00, i[0], {2'b10, pa[7:0]});
      chk_flag(1'b0, device_busy);
    end
    $display("program poll done");
    cmd(FSR_CMD_WRITE, {5'h07, 16'h0000}, 8'h30, 1'b0, 10'h000);
    cmd(FSR_CMD_POLL, {5'h07, 16'h0000}, 8'h00, 1'b0, 10'h100);
    cmd(FSR_CMD_RESET, '0, 8'h00, 1'b0, 10'h000);
    chk_flag(1'b1, dur <= READY_BUSY_CYC + 20);
    chk_flag(1'b0, device_busy);
    cmd(FSR_CMD_RESET, '0, 8'h00, 1'b0, 10'h000);
    chk_flag(1'b1, dur <= READY_IDLE_CYC + 10);
    cmd(FSR_CMD_STANDBY, '0, 8'h00, 1'b0, 10'h000);
    chk_flag(1'b1, dur >= STANDBY_CYC);
    $display("reset tests done");
    seed = xs(seed);
    cmd(FSR_CMD_PROTECT, {seed[4:0], 16'h0000}, 8'h00, 1'b0, 10'h201);
    chk_flag(1'b1, dur >= PROT_PULSE_CYC);
    cmd(FSR_CMD_UNPROTECT, {seed[9:5], 16'h0000}, 8'h00, 1'b0, 10'h200);
    chk_flag(1'b1, dur >= 20);
    $display("protect tests done");
    final_report();
  end
endmodule
